// File: core/serial_receiver.v
// Purpose: receive side of a serial port with error flags and address detect
// Assumes: AHB-Lite slave, one clock ref_clk, asynchronous active-low rstn
// Notes  : async bit period is baud divisor plus one ref_clk cycles; an internal sync clock bit takes twice that
//
// Notes on behaviour
// - pending flag: receiver on and data queued
// - flag ignores enables; irq needs peripheral and global enables plus rxie (pending) or a mask bit (status)
// - each queued character keeps its framing status
// - framing flag follows oldest unread character
// - framing error neither stops reception nor interrupts
// - port disable clears framing; receive disable not
// - two-deep queue; third character sets overrun
// - overrun keeps queue readable, blocks new characters
// - only receive or port disable clears overrun
// - nine-bit mode shifts nine; ninth bit shown
// - address detect in nine-bit mode keeps only ninth-bit-set characters
`timescale 1ns/10ps
`default_nettype none
`include "serial_rx_defines.vh"

module serial_receiver (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    input  wire        rxIn,
    input  wire        syncClkIn,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg         irq_ff,
    output reg         syncClkOut_ff,
    output reg         syncClkOe_ff,
    output reg         txActive_ff,
    output reg         txNineBit_ff
);

    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_START = 4'b0010;
    localparam [3:0] ST_DATA  = 4'b0100;
    localparam [3:0] ST_STOP  = 4'b1000;

    reg        serialPortEnable_ff, nineBitReceiveSelect_ff;
    reg        continuousReceiveEnable_ff, addressDetectEnable_ff;
    reg        overrunErrorFlag_ff, rxPendingFlag_ff;
    reg        clockSourceSelect_ff, nineBitTransmitSelect_ff, transmitterEnable_ff;
    reg        syncModeSelect_ff, breakSendRequest_ff, highBaudSelect_ff;
    reg        transmitNinthBit_ff;
    reg        rxPendingIrqEnable_ff, peripheralIrqEnable_ff, globalIrqEnable_ff;
    reg [1:0]  irqStat_ff, irqMask_ff;
    reg [15:0] baudDiv_ff, baudCnt_ff;
    reg [2:0]  rxSync_ff, ckSync_ff;
    reg        rxLvl_ff, rxPrev_ff, ckLvl_ff, ckPrev_ff;
    reg [3:0]  state_ff, bitCnt_ff;
    reg [8:0]  shift_ff;
    reg        done_ff;
    reg [9:0]  doneChar_ff;
    reg [1:0]  count_ff;
    reg        wrPtr_ff, rdPtr_ff;
    reg        dph_ff, dWrite_ff;
    reg [7:0]  dAddr_ff;
    reg [31:0] rdMux;

    wire [9:0] headChar;
    wire       rxOn     = serialPortEnable_ff & continuousReceiveEnable_ff;
    wire       busTake  = hsel & hready & htrans[1];
    wire       wrSel    = dph_ff & dWrite_ff;
    wire       rdSel    = dph_ff & ~dWrite_ff;
    wire       notEmpty = (count_ff != 2'h0);
    wire       pop      = rdSel & (dAddr_ff == `OFS_RX_DATA) & notEmpty;
    wire [3:0] lastIdx  = nineBitReceiveSelect_ff ? `BITS_NINE_LAST : `BITS_EIGHT_LAST;
    wire       lastBit  = (bitCnt_ff == lastIdx);
    wire [8:0] nxt_shift = {rxLvl_ff, shift_ff[8:1]};
    wire [8:0] shiftChar = nineBitReceiveSelect_ff ? shift_ff : {1'b0, shift_ff[8:1]};
    wire [8:0] nxt_char  = nineBitReceiveSelect_ff ? nxt_shift : {1'b0, nxt_shift[8:1]};
    // an internal clock rises when the divider expires while the pin is low
    wire       syncTick = clockSourceSelect_ff ?
                          ((baudCnt_ff == 16'h0000) & ~syncClkOut_ff) :
                          (ckLvl_ff & ~ckPrev_ff);
    // nine-bit characters with the ninth bit clear are dropped while hunting an address
    wire       keep     = done_ff & rxOn & ~overrunErrorFlag_ff &
                          ~(addressDetectEnable_ff & nineBitReceiveSelect_ff &
                            ~doneChar_ff[8]);
    wire       full     = (count_ff == `FIFO_FULL_CNT) & ~pop;
    wire       push     = keep & ~full;
    wire       ovrSet   = keep & full;
    wire       headFerr = notEmpty & headChar[9];
    wire       headNine = notEmpty & headChar[8];

    // ======================================================================
    // pin synchronisers: a change counts once stages two and three agree
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rxSync_ff <= 3'h7;
            ckSync_ff <= 3'h0;
            rxLvl_ff  <= 1'b1;
            rxPrev_ff <= 1'b1;
            ckLvl_ff  <= 1'b0;
            ckPrev_ff <= 1'b0;
        end
        else
        begin
            rxSync_ff <= {rxSync_ff[1:0], rxIn};
            ckSync_ff <= {ckSync_ff[1:0], syncClkIn};
            if (rxSync_ff[1] == rxSync_ff[2])
                rxLvl_ff <= rxSync_ff[2];
            if (ckSync_ff[1] == ckSync_ff[2])
                ckLvl_ff <= ckSync_ff[2];
            rxPrev_ff <= rxLvl_ff;
            ckPrev_ff <= ckLvl_ff;
        end
    end

    // ======================================================================
    // character framing
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff      <= ST_IDLE;
            baudCnt_ff    <= 16'h0000;
            bitCnt_ff     <= 4'h0;
            shift_ff      <= 9'h000;
            syncClkOut_ff <= 1'b0;
            done_ff       <= 1'b0;
            doneChar_ff   <= 10'h000;
        end
        else
        begin
            done_ff <= 1'b0;
            if (!rxOn)
            begin
                state_ff      <= ST_IDLE;
                bitCnt_ff     <= 4'h0;
                baudCnt_ff    <= baudDiv_ff;
                syncClkOut_ff <= 1'b0;
            end
            else if (syncModeSelect_ff)
            begin
                state_ff <= ST_DATA;
                if (clockSourceSelect_ff)
                begin
                    if (baudCnt_ff == 16'h0000)
                    begin
                        baudCnt_ff    <= baudDiv_ff;
                        syncClkOut_ff <= ~syncClkOut_ff;
                    end
                    else
                        baudCnt_ff <= baudCnt_ff - 16'h0001;
                end
                if (syncTick)
                begin
                    shift_ff <= nxt_shift;
                    if (lastBit)
                    begin
                        bitCnt_ff   <= 4'h0;
                        done_ff     <= 1'b1;
                        doneChar_ff <= {1'b0, nxt_char};
                    end
                    else
                        bitCnt_ff <= bitCnt_ff + 4'h1;
                end
            end
            else
            begin
                case (state_ff)
                    ST_IDLE:
                    begin
                        if (rxPrev_ff && !rxLvl_ff)
                        begin
                            state_ff   <= ST_START;
                            baudCnt_ff <= {1'b0, baudDiv_ff[15:1]};
                        end
                    end
                    ST_START:
                    begin
                        if (baudCnt_ff != 16'h0000)
                            baudCnt_ff <= baudCnt_ff - 16'h0001;
                        else if (!rxLvl_ff)
                        begin
                            state_ff   <= ST_DATA;
                            baudCnt_ff <= baudDiv_ff;
                            bitCnt_ff  <= 4'h0;
                        end
                        else
                            state_ff <= ST_IDLE;
                    end
                    ST_DATA:
                    begin
                        if (baudCnt_ff != 16'h0000)
                            baudCnt_ff <= baudCnt_ff - 16'h0001;
                        else
                        begin
                            shift_ff   <= nxt_shift;
                            baudCnt_ff <= baudDiv_ff;
                            if (lastBit)
                            begin
                                state_ff  <= ST_STOP;
                                bitCnt_ff <= 4'h0;
                            end
                            else
                                bitCnt_ff <= bitCnt_ff + 4'h1;
                        end
                    end
                    ST_STOP:
                    begin
                        if (baudCnt_ff != 16'h0000)
                            baudCnt_ff <= baudCnt_ff - 16'h0001;
                        else
                        begin
                            // a low stop sample still delivers the character
                            done_ff     <= 1'b1;
                            doneChar_ff <= {~rxLvl_ff, shiftChar};
                            state_ff    <= ST_IDLE;
                        end
                    end
                    default:
                        state_ff <= ST_IDLE;
                endcase
            end
        end
    end

    // ======================================================================
    // receive queue control
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count_ff            <= 2'h0;
            wrPtr_ff            <= 1'b0;
            rdPtr_ff            <= 1'b0;
            overrunErrorFlag_ff <= 1'b0;
            rxPendingFlag_ff    <= 1'b0;
        end
        else if (!serialPortEnable_ff)
        begin
            // port disable empties the queue, which also clears framing status
            count_ff            <= 2'h0;
            wrPtr_ff            <= 1'b0;
            rdPtr_ff            <= 1'b0;
            overrunErrorFlag_ff <= 1'b0;
            rxPendingFlag_ff    <= 1'b0;
        end
        else
        begin
            if (!continuousReceiveEnable_ff)
                overrunErrorFlag_ff <= 1'b0;
            else if (ovrSet)
                overrunErrorFlag_ff <= 1'b1;
            if (push)
                wrPtr_ff <= ~wrPtr_ff;
            if (pop)
                rdPtr_ff <= ~rdPtr_ff;
            if (push && !pop)
                count_ff <= count_ff + 2'h1;
            else if (pop && !push)
                count_ff <= count_ff - 2'h1;
            rxPendingFlag_ff <= rxOn & notEmpty;
        end
    end

    rx_char_store u_store (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .wrEn      (push),
        .wrAddr    (wrPtr_ff),
        .wrData    (doneChar_ff),
        .rdAddr    (rdPtr_ff),
        .rdData_ff (headChar)
    );

    // ======================================================================
    // bus slave: one wait state on every transfer, always OKAY
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dph_ff    <= 1'b0;
            dWrite_ff <= 1'b0;
            dAddr_ff  <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
        end
        else
        begin
            hresp <= 1'b0;
            if (busTake)
            begin
                dph_ff    <= 1'b1;
                dWrite_ff <= hwrite;
                dAddr_ff  <= {haddr[7:2], 2'b00};
                hreadyout <= 1'b0;
            end
            else if (dph_ff)
            begin
                dph_ff    <= 1'b0;
                hreadyout <= 1'b1;
                hrdata    <= dWrite_ff ? 32'h00000000 : rdMux;
            end
        end
    end

    // status bits are valid before the data word is popped
    always @*
    begin
        rdMux = 32'h00000000;
        case (dAddr_ff)
            `OFS_RX_STAT_CTRL: rdMux[7:0] = {serialPortEnable_ff, nineBitReceiveSelect_ff,
                                             1'b0, continuousReceiveEnable_ff,
                                             addressDetectEnable_ff, headFerr,
                                             overrunErrorFlag_ff, headNine};
            `OFS_TX_STAT_CTRL: rdMux[7:0] = {clockSourceSelect_ff, nineBitTransmitSelect_ff,
                                             transmitterEnable_ff, syncModeSelect_ff,
                                             breakSendRequest_ff, highBaudSelect_ff,
                                             1'b1, transmitNinthBit_ff};
            `OFS_RX_DATA:      rdMux[7:0] = notEmpty ? headChar[7:0] : 8'h00;
            `OFS_BAUD_DIV:     rdMux[15:0] = baudDiv_ff;
            `OFS_IRQ_STAT:     rdMux[8:0] = {rxPendingFlag_ff, 6'h00, irqStat_ff};
            `OFS_IRQ_MASK:     rdMux[1:0] = irqMask_ff;
            `OFS_IRQ_CTRL:     rdMux[2:0] = {globalIrqEnable_ff, peripheralIrqEnable_ff,
                                             rxPendingIrqEnable_ff};
            default:           rdMux = 32'h00000000;
        endcase
    end

    // ======================================================================
    // control registers and interrupt
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            serialPortEnable_ff        <= 1'b0;
            nineBitReceiveSelect_ff    <= 1'b0;
            continuousReceiveEnable_ff <= 1'b0;
            addressDetectEnable_ff     <= 1'b0;
            clockSourceSelect_ff       <= 1'b0;
            nineBitTransmitSelect_ff   <= 1'b0;
            transmitterEnable_ff       <= 1'b0;
            syncModeSelect_ff          <= 1'b0;
            breakSendRequest_ff        <= 1'b0;
            highBaudSelect_ff          <= 1'b0;
            transmitNinthBit_ff        <= 1'b0;
            baudDiv_ff                 <= `BAUD_DIV_RST;
            irqStat_ff                 <= 2'h0;
            irqMask_ff                 <= 2'h0;
            rxPendingIrqEnable_ff      <= 1'b0;
            peripheralIrqEnable_ff     <= 1'b0;
            globalIrqEnable_ff         <= 1'b0;
            irq_ff                     <= 1'b0;
            syncClkOe_ff               <= 1'b0;
            txActive_ff                <= 1'b0;
            txNineBit_ff               <= 1'b0;
        end
        else
        begin
            if (wrSel && dAddr_ff == `OFS_RX_STAT_CTRL)
            begin
                serialPortEnable_ff        <= hwdata[`RXC_SERIAL_PORT_ENABLE];
                nineBitReceiveSelect_ff    <= hwdata[`RXC_RX9];
                continuousReceiveEnable_ff <= hwdata[`RXC_CONTINUOUS_RECEIVE_ENABLE];
                addressDetectEnable_ff     <= hwdata[`RXC_ADDRESS_DETECT_ENABLE];
            end
            if (wrSel && dAddr_ff == `OFS_TX_STAT_CTRL)
            begin
                clockSourceSelect_ff     <= hwdata[`TXC_CLOCK_SOURCE_SELECT];
                nineBitTransmitSelect_ff <= hwdata[`TXC_TX9];
                transmitterEnable_ff     <= hwdata[`TXC_TRANSMITTER_ENABLE];
                syncModeSelect_ff        <= hwdata[`TXC_SYNC];
                breakSendRequest_ff      <= hwdata[`TXC_BREAK_SEND_REQUEST];
                highBaudSelect_ff        <= hwdata[`TXC_HIGH_BAUD_SELECT];
                transmitNinthBit_ff      <= hwdata[`TXC_TRANSMIT_NINTH_BIT];
            end
            if (wrSel && dAddr_ff == `OFS_BAUD_DIV)
                baudDiv_ff <= hwdata[15:0];
            if (wrSel && dAddr_ff == `OFS_IRQ_MASK)
                irqMask_ff <= hwdata[1:0];
            if (wrSel && dAddr_ff == `OFS_IRQ_CTRL)
            begin
                rxPendingIrqEnable_ff  <= hwdata[`ICTL_RXIE];
                peripheralIrqEnable_ff <= hwdata[`ICTL_PERIPHERAL_IRQ_ENABLE];
                globalIrqEnable_ff     <= hwdata[`ICTL_GIE];
            end
            // a new event in the clearing cycle survives the clear
            irqStat_ff <= (irqStat_ff & ~((wrSel && dAddr_ff == `OFS_IRQ_STAT) ?
                          hwdata[1:0] : 2'h0)) | {ovrSet, push};
            // framing errors have no event bit of their own
            irq_ff <= peripheralIrqEnable_ff & globalIrqEnable_ff &
                      ((rxPendingFlag_ff & rxPendingIrqEnable_ff) |
                       (|(irqStat_ff & irqMask_ff)));
            syncClkOe_ff <= serialPortEnable_ff & syncModeSelect_ff &
                            clockSourceSelect_ff;
            txActive_ff  <= serialPortEnable_ff & transmitterEnable_ff;
            txNineBit_ff <= nineBitTransmitSelect_ff;
        end
    end

endmodule // serial_receiver
`default_nettype wire

// File: core/serial_rx_defines.vh
// Purpose: constants shared by the serial receiver core and its store
// Assumes: registers are 32-bit aligned words on an AHB-Lite slave
// Notes  : offsets are byte addresses; bit positions are within each word
`ifndef SERIAL_RX_DEFINES_VH
`define SERIAL_RX_DEFINES_VH

// ==========================================================================
// register offsets
`define OFS_RX_STAT_CTRL   8'h00
`define OFS_TX_STAT_CTRL   8'h04
`define OFS_RX_DATA        8'h08
`define OFS_BAUD_DIV       8'h0c
`define OFS_IRQ_STAT       8'h10
`define OFS_IRQ_MASK       8'h14
`define OFS_IRQ_CTRL       8'h18

// ==========================================================================
// receive_status_control fields
`define RXC_SERIAL_PORT_ENABLE           7
`define RXC_RX9            6
`define RXC_CONTINUOUS_RECEIVE_ENABLE           4
`define RXC_ADDRESS_DETECT_ENABLE          3
`define RXC_FRAMING_ERROR_FLAG           2
`define RXC_OVERRUN_ERROR_FLAG           1
`define RXC_RECEIVED_NINTH_BIT           0

// ==========================================================================
// transmit_status_control fields
`define TXC_CLOCK_SOURCE_SELECT           7
`define TXC_TX9            6
`define TXC_TRANSMITTER_ENABLE           5
`define TXC_SYNC           4
`define TXC_BREAK_SEND_REQUEST          3
`define TXC_HIGH_BAUD_SELECT           2
`define TXC_SHIFT_REGISTER_EMPTY           1
`define TXC_TRANSMIT_NINTH_BIT           0
`define TXC_RST            8'h02

// ==========================================================================
// interrupt fields, reset values, sizes
`define IRQ_CHAR           0
`define IRQ_OVR            1
`define IRQ_PEND_RO        8
`define ICTL_RXIE          0
`define ICTL_PERIPHERAL_IRQ_ENABLE          1
`define ICTL_GIE           2
`define BAUD_DIV_RST       16'h000f
`define CHAR_W             10
`define FIFO_DEPTH         2
`define FIFO_FULL_CNT      2'h2
`define BITS_NINE_LAST     4'h8
`define BITS_EIGHT_LAST    4'h7

`endif

// File: core/rx_char_store.v
// Purpose: two-entry character store behind the receive queue
// Assumes: one write port and one read address, same clock
// Notes  : read data are registered, so they follow the address a cycle late
`timescale 1ns/10ps
`default_nettype none
`include "serial_rx_defines.vh"

module rx_char_store (
    input  wire                   ref_clk,
    input  wire                   rstn,
    input  wire                   wrEn,
    input  wire                   wrAddr,
    input  wire [`CHAR_W-1:0]     wrData,
    input  wire                   rdAddr,
    output reg  [`CHAR_W-1:0]     rdData_ff
);

    wire [`CHAR_W-1:0] entry [0:`FIFO_DEPTH-1];

    // ======================================================================
    // storage entries
    genvar gi;
    generate
        for (gi = 0; gi < `FIFO_DEPTH; gi = gi + 1)
        begin : g_entry
            reg [`CHAR_W-1:0] slot_ff;
            always @(posedge ref_clk or negedge rstn)
            begin
                if (!rstn)
                    slot_ff <= {`CHAR_W{1'b0}};
                else if (wrEn && (wrAddr == gi))
                    slot_ff <= wrData;
            end
            assign entry[gi] = slot_ff;
        end
    endgenerate

    // ======================================================================
    // registered read port
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            rdData_ff <= {`CHAR_W{1'b0}};
        else
            rdData_ff <= entry[rdAddr];
    end

endmodule // rx_char_store
`default_nettype wire

// File: dv/serial_receiver_sva.sv
// Purpose: port checker for the serial receiver
// Assumes: one slave, hready looped back
// Notes  : shadows written control words
`timescale 1ns/10ps
`default_nettype none
module serial_receiver_sva (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq_ff,
    input wire logic        syncClkOut_ff,
    input wire logic        syncClkOe_ff,
    input wire logic        txActive_ff,
    input wire logic        txNineBit_ff
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic       wp_ff;
    logic [5:0] wa_ff;
    logic [7:0] rxc_ff, txc_ff, ictl_ff;
    wire        taken = hsel & hready & htrans[1];
    // ====
    // shadow registers, written at the edge that ends the wait state
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wp_ff   <= 1'b0;
            wa_ff   <= 6'h00;
            rxc_ff  <= 8'h00;
            txc_ff  <= 8'h02;
            ictl_ff <= 8'h00;
        end
        else if (taken)
        begin
            wp_ff <= hwrite;
            wa_ff <= haddr[7:2];
        end
        else if (wp_ff && !hreadyout)
        begin
            wp_ff <= 1'b0;
            if (wa_ff == 6'h00) rxc_ff <= hwdata[7:0];
            if (wa_ff == 6'h01) txc_ff <= hwdata[7:0];
            if (wa_ff == 6'h06) ictl_ff <= hwdata[7:0];
        end
    end
    // ====
    wait_state_a: assert property (taken |=> !hreadyout ##1 hreadyout)
        else $error("wait state wrong");
    ready_cause_a: assert property ($fell(hreadyout) |-> $past(taken))
        else $error("stray wait state");
    okay_resp_a: assert property (!hresp)
        else $error("response not okay");
    upper_zero_a: assert property (hrdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    tx_enable_a: assert property (txActive_ff == $past(rxc_ff[7] & txc_ff[5]))
        else $error("transmit enable wrong");
    tx_width_a: assert property (txNineBit_ff == $past(txc_ff[6]))
        else $error("transmit width wrong");
    clk_drive_a: assert property (
        syncClkOe_ff == $past(&{rxc_ff[7], txc_ff[7], txc_ff[4]}))
        else $error("clock drive wrong");
    clk_src_a: assert property (
        $changed(syncClkOut_ff) |-> syncClkOe_ff || $past(syncClkOe_ff))
        else $error("clock runs undriven");
    irq_gate_a: assert property (irq_ff |-> $past(ictl_ff[1] & ictl_ff[2]))
        else $error("irq without enables");
    cover property ($rose(irq_ff));
    cover property ($changed(syncClkOut_ff));
    cover property (taken && hwrite);
endmodule // serial_receiver_sva
`default_nettype wire

// File: dv/serial_line_model.sv
// Purpose: remote transmitter on the shared line
// Assumes: async frames of BIT cycles a bit
// Notes  : line idles high, clock pin stands still
`timescale 1ns/10ps
`default_nettype none
module serial_line_model #(parameter int BIT = 8) (
    input  wire logic ref_clk,
    output var  logic rxIn,
    output var  logic syncClkIn
);
    initial
    begin
        rxIn = 1'b1;
        syncClkIn = 1'b0;
    end
    // ====
    // start, data LSB first, stop, then one idle bit in eight-bit frames only
    task automatic send(input logic [8:0] d, input logic nine, input logic stopOk);
        logic [10:0] f;
        f = nine ? {stopOk, d, 1'b0} : {1'b1, stopOk, d[7:0], 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            @(posedge ref_clk);
            rxIn <= f[i];
            repeat (BIT - 1) @(posedge ref_clk);
        end
    endtask
endmodule // serial_line_model
`default_nettype wire

// File: dv/serial_receiver_tb.sv
// Purpose: self-checking bench for the serial receiver
// Assumes: one slave, hready looped from hreadyout
// Notes  : divisor 7 gives an 8-cycle bit
`timescale 1ns/10ps
`default_nettype none
module serial_receiver_tb;
    logic        ref_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        rdPend = 1'b0, rdLow = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h000152a6;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, irq_ff, syncClkOut_ff, syncClkOe_ff;
    logic        txActive_ff, txNineBit_ff, rxIn, syncClkIn;
    wire         hready = hreadyout;
    logic [31:0] expQ[$];
    logic [7:0]  c [4];
    int          n_fail = 0, tests_run = 0;
    serial_receiver u_dut (.*);
    serial_line_model #(.BIT(8)) u_line (.*);
    initial forever #50 ref_clk = ~ref_clk;
    // ====
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask
    task automatic settle;
        repeat (24) @(posedge ref_clk);
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge ref_clk);
        check({31'h0, irq_ff}, {31'h0, e});
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ====
    // read data monitor: compares at the edge that ends the data phase
    always @(posedge ref_clk)
    begin
        if (rdLow && hreadyout === 1'b1)
        begin
            check(hrdata, expQ.pop_front());
            rdLow = 1'b0;
        end
        if (rdPend && hreadyout === 1'b0)
        begin
            rdLow  = 1'b1;
            rdPend = 1'b0;
        end
        if (hsel && htrans[1] && !hwrite && hready === 1'b1)
            rdPend = 1'b1;
    end
    initial
    begin
        #2000000;
        n_fail++;
        report_and_stop;
    end
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(8'h04, 32'h02);
        rd(8'h0c, 32'h0f);
        rd(8'h1c, 32'h00);
        bus(8'h0c, 1'b1, 32'h7);
        bus(8'h04, 1'b1, 32'hf0);
        bus(8'h00, 1'b1, 32'h90);
        rd(8'h04, 32'hf2);
        repeat (40) @(posedge ref_clk);
        bus(8'h00, 1'b1, 32'h0);
        bus(8'h04, 1'b1, 32'h0);
        $display("test registers done");
        bus(8'h18, 1'b1, 32'h3);
        bus(8'h00, 1'b1, 32'h90);
        foreach (c[i]) c[i] = rnd();
        u_line.send({1'b0, c[0]}, 1'b0, 1'b1);
        u_line.send({1'b0, c[1]}, 1'b0, 1'b0);
        settle;
        irq_is(1'b0);
        bus(8'h18, 1'b1, 32'h7);
        irq_is(1'b1);
        bus(8'h18, 1'b1, 32'h6);
        rd(8'h10, 32'h101);
        rd(8'h00, 32'h90);
        rd(8'h08, {24'h0, c[0]});
        rd(8'h00, 32'h94);
        rd(8'h08, {24'h0, c[1]});
        rd(8'h10, 32'h001);
        bus(8'h14, 1'b1, 32'h1);
        irq_is(1'b1);
        bus(8'h10, 1'b1, 32'h1);
        irq_is(1'b0);
        bus(8'h14, 1'b1, 32'h0);
        $display("test receive done");
        for (int i = 0; i < 3; i++) u_line.send({1'b0, c[i]}, 1'b0, 1'b1);
        settle;
        rd(8'h00, 32'h92);
        u_line.send({1'b0, c[3]}, 1'b0, 1'b1);
        settle;
        rd(8'h08, {24'h0, c[0]});
        rd(8'h08, {24'h0, c[1]});
        rd(8'h08, 32'h0);
        bus(8'h00, 1'b1, 32'h80);
        rd(8'h00, 32'h80);
        bus(8'h00, 1'b1, 32'h90);
        u_line.send({1'b0, c[3]}, 1'b0, 1'b1);
        settle;
        rd(8'h08, {24'h0, c[3]});
        bus(8'h00, 1'b1, 32'hd8);
        u_line.send({1'b0, c[0]}, 1'b1, 1'b1);
        u_line.send({1'b1, c[1]}, 1'b1, 1'b1);
        settle;
        rd(8'h00, 32'hd9);
        rd(8'h08, {24'h0, c[1]});
        bus(8'h00, 1'b1, 32'hd0);
        u_line.send({1'b0, c[2]}, 1'b1, 1'b1);
        settle;
        rd(8'h00, 32'hd0);
        rd(8'h08, {24'h0, c[2]});
        bus(8'h00, 1'b1, 32'h90);
        u_line.send({1'b0, c[0]}, 1'b0, 1'b0);
        settle;
        bus(8'h00, 1'b1, 32'h80);
        rd(8'h00, 32'h84);
        bus(8'h00, 1'b1, 32'h00);
        rd(8'h00, 32'h00);
        $display("test errors done");
        report_and_stop;
    end
endmodule // serial_receiver_tb
bind serial_receiver serial_receiver_sva u_sva (.*);
`default_nettype wire
